// ---- gpib_status_pkg.sv ----
`default_nettype none
package gpib_status_pkg;
    localparam logic [4:0] reg_card_identity = 5'h01;
    localparam logic [4:0] reg_irq_dma = 5'h03;
    localparam logic [4:0] reg_ctrl_status = 5'h05;
    localparam logic [4:0] reg_irq_status_hi = 5'h11;
    localparam logic [4:0] reg_irq_status_lo = 5'h13;
    localparam logic [4:0] reg_iface_status = 5'h15;
    localparam logic [4:0] reg_ctrl_lines = 5'h17;
    localparam logic [4:0] reg_cmd_pass = 5'h1d;
    localparam logic [4:0] reg_data_lines = 5'h1f;
    localparam logic [4:0] reg_enable_lo = 5'h00;
    localparam logic [4:0] reg_enable_hi = 5'h02;
    localparam logic [4:0] reg_own_address = 5'h04;
    localparam int id_jumper_bit = 7;
    localparam int addr_lsb_bit = 8;
    localparam int snap_ndac_bit = 13;
    localparam int snap_nrfd_bit = 12;
    localparam int snap_srq_bit = 10;
    localparam int ctl_active_bit = 6;
    localparam int ctl_system_bit = 7;
    localparam int state_talker_bit = 9;
    localparam logic [15:0] enable_reset = 16'h0000;
    localparam logic [4:0] own_address_reset = 5'h00;
    localparam logic [7:0] float_value = 8'hff;
endpackage
`default_nettype wire

// ---- gpib_byte_decode.sv ----
`default_nettype none
module gpib_byte_decode
(
    input wire logic [4:0] addr,
    output logic read_clears_lo,
    output logic read_clears_hi,
    output logic read_acks_data
);
    // reads that change state
    always_comb
    begin
        read_clears_hi = (addr == gpib_status_pkg::reg_irq_status_hi);
        read_clears_lo = (addr == gpib_status_pkg::reg_irq_status_lo);
        read_acks_data = (addr == gpib_status_pkg::reg_data_lines);
    end
endmodule
`default_nettype wire

// ---- gpib_status_interrupt_view.sv ----
// Notes on behaviour
// - identity top bit shows jumper fitted
// - identity low seven bits fixed code
// - built-in variant floats the identity byte
// - snapshot: control lines high, data low
// - handshake bits valid only when talker
// - srq bit valid only as controller
// - bit 8 holds last address lsb
// - enable mask mirrors cause bit positions
// - fixed byte read map offsets
// - cause and data reads change state
`default_nettype none
module gpib_status_interrupt_view
#(
    parameter logic [6:0] card_code = 7'h2a, // arbitrary value
    parameter bit plug_in_card = 1'b1
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [4:0] byte_port_addr,
    input wire logic byte_port_read,
    input wire logic byte_port_write,
    input wire logic [7:0] byte_port_wdata,
    output logic [7:0] byte_port_rdata,
    input wire logic jumper_fitted,
    input wire logic [15:0] cause_events,
    input wire logic [7:0] bus_ctrl_lines,
    input wire logic [7:0] bus_data_lines,
    input wire logic [15:0] iface_state_in,
    input wire logic addr_recognised,
    input wire logic [7:0] recognised_address,
    input wire logic [7:0] unknown_command,
    input wire logic [7:0] irq_dma_bits,
    output logic data_read_ack,
    output logic [4:0] own_address,
    output logic irq
);
    ////////////////////////////////////////////////////////////////
    logic [15:0] cause, next_cause;
    logic [15:0] enable, next_enable;
    logic [4:0] next_own_address;
    logic last_addr_lsb, next_last_addr_lsb;
    logic [7:0] next_rdata;
    logic next_data_read_ack;
    logic clr_lo, clr_hi, acks_data;
    logic [15:0] state_word, snapshot;

    gpib_byte_decode u_decode
    (
        .addr(byte_port_addr),
        .read_clears_lo(clr_lo),
        .read_clears_hi(clr_hi),
        .read_acks_data(acks_data)
    );

    always_comb
    begin
        state_word = iface_state_in;
        state_word[gpib_status_pkg::addr_lsb_bit] = last_addr_lsb;
        snapshot = {bus_ctrl_lines, bus_data_lines};
        // stale values would mislead software, so invalid bits read zero
        if (!iface_state_in[gpib_status_pkg::state_talker_bit])
        begin
            snapshot[gpib_status_pkg::snap_ndac_bit] = 1'b0;
            snapshot[gpib_status_pkg::snap_nrfd_bit] = 1'b0;
        end
        if (!iface_state_in[gpib_status_pkg::ctl_active_bit])
        begin
            snapshot[gpib_status_pkg::snap_srq_bit] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_cause = cause;
        next_enable = enable;
        next_own_address = own_address;
        next_last_addr_lsb = last_addr_lsb;
        next_data_read_ack = byte_port_read && acks_data;
        if (byte_port_read && clr_hi)
        begin
            next_cause[15:8] = 8'h00;
        end
        if (byte_port_read && clr_lo)
        begin
            next_cause[7:0] = 8'h00;
        end
        next_cause = next_cause | cause_events; // set beats clear
        if (addr_recognised)
        begin
            next_last_addr_lsb = recognised_address[0];
        end
        if (byte_port_write)
        begin
            case (byte_port_addr)
                gpib_status_pkg::reg_enable_lo: next_enable[7:0] = byte_port_wdata;
                gpib_status_pkg::reg_enable_hi: next_enable[15:8] = byte_port_wdata;
                gpib_status_pkg::reg_own_address: next_own_address = byte_port_wdata[4:0];
                default: next_enable = next_enable;
            endcase
        end
        next_rdata = 8'h00;
        if (byte_port_read)
        begin
            case (byte_port_addr)
                gpib_status_pkg::reg_card_identity:
                    next_rdata = plug_in_card ? {jumper_fitted, card_code}
                                              : gpib_status_pkg::float_value;
                gpib_status_pkg::reg_irq_dma: next_rdata = irq_dma_bits;
                gpib_status_pkg::reg_ctrl_status: next_rdata = state_word[7:0];
                gpib_status_pkg::reg_irq_status_hi: next_rdata = cause[15:8];
                gpib_status_pkg::reg_irq_status_lo: next_rdata = cause[7:0];
                gpib_status_pkg::reg_iface_status: next_rdata = state_word[15:8];
                gpib_status_pkg::reg_ctrl_lines: next_rdata = snapshot[15:8];
                gpib_status_pkg::reg_cmd_pass: next_rdata = unknown_command;
                gpib_status_pkg::reg_data_lines: next_rdata = snapshot[7:0];
                gpib_status_pkg::reg_enable_lo: next_rdata = enable[7:0];
                gpib_status_pkg::reg_enable_hi: next_rdata = enable[15:8];
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cause <= 16'h0000;
            enable <= gpib_status_pkg::enable_reset;
            own_address <= gpib_status_pkg::own_address_reset;
            last_addr_lsb <= 1'b0;
            byte_port_rdata <= 8'h00;
            data_read_ack <= 1'b0;
        end
        else
        begin
            cause <= next_cause;
            enable <= next_enable;
            own_address <= next_own_address;
            last_addr_lsb <= next_last_addr_lsb;
            byte_port_rdata <= next_rdata;
            data_read_ack <= next_data_read_ack;
        end
    end

    assign irq = |(cause & enable);

    ////////////////////////////////////////////////////////////////
    // offsets that return data on a read; the rest read zero
    function automatic logic read_mapped(input logic [4:0] a);
        case (a)
            gpib_status_pkg::reg_card_identity,
            gpib_status_pkg::reg_irq_dma,
            gpib_status_pkg::reg_ctrl_status,
            gpib_status_pkg::reg_irq_status_hi,
            gpib_status_pkg::reg_irq_status_lo,
            gpib_status_pkg::reg_iface_status,
            gpib_status_pkg::reg_ctrl_lines,
            gpib_status_pkg::reg_cmd_pass,
            gpib_status_pkg::reg_data_lines,
            gpib_status_pkg::reg_enable_lo,
            gpib_status_pkg::reg_enable_hi: read_mapped = 1'b1;
            default: read_mapped = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////
    chk_id_jumper_bit: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_card_identity && plug_in_card
        |=> byte_port_rdata[7] == $past(jumper_fitted))
        else $error("identity jumper bit wrong");
    chk_id_code: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_card_identity && plug_in_card
        |=> byte_port_rdata[6:0] == card_code)
        else $error("identity code wrong");
    // a write in the same cycle could move the mask, so it is left out
    chk_irq_level: assert property (@(posedge core_clk) disable iff (rst)
        (cause_events & enable) != 16'h0000 && !byte_port_write |=> irq)
        else $error("irq level mismatch");
    chk_irq_quiet: assert property (@(posedge core_clk) disable iff (rst)
        enable == 16'h0000 && !byte_port_write |=> !irq)
        else $error("irq raised with empty mask");
    chk_event_sticky: assert property (@(posedge core_clk) disable iff (rst)
        cause_events[0] |=> cause[0])
        else $error("event lost");
    chk_read_clears: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && clr_hi && cause_events[15:8] == 8'h00 |=> cause[15:8] == 8'h00)
        else $error("cause not cleared by read");
    chk_lsb_held: assert property (@(posedge core_clk) disable iff (rst)
        addr_recognised |=> last_addr_lsb == $past(recognised_address[0]))
        else $error("address lsb not captured");
    chk_srq_masked: assert property (@(posedge core_clk) disable iff (rst)
        !iface_state_in[gpib_status_pkg::ctl_active_bit] |-> !snapshot[gpib_status_pkg::snap_srq_bit])
        else $error("srq shown when not controller");
    chk_talk_masked: assert property (@(posedge core_clk) disable iff (rst)
        !iface_state_in[gpib_status_pkg::state_talker_bit] |-> snapshot[13:12] == 2'b00)
        else $error("handshake shown when not talker");
    chk_enable_write: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_write && byte_port_addr == gpib_status_pkg::reg_enable_lo
        |=> enable[7:0] == $past(byte_port_wdata))
        else $error("enable write lost");
    chk_enable_hi_write: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_write && byte_port_addr == gpib_status_pkg::reg_enable_hi
        |=> enable[15:8] == $past(byte_port_wdata))
        else $error("enable high write lost");
    chk_enable_lo_read: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_enable_lo
        |=> byte_port_rdata == $past(enable[7:0]))
        else $error("enable low read wrong");
    chk_enable_hi_read: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_enable_hi
        |=> byte_port_rdata == $past(enable[15:8]))
        else $error("enable high read wrong");
    chk_builtin_float: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_card_identity && !plug_in_card
        |=> byte_port_rdata == gpib_status_pkg::float_value)
        else $error("built-in identity not floating");
    // lines valid in every role: atn, dav, eoi, ifc, ren
    chk_ctrl_lines: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_ctrl_lines
        |=> (byte_port_rdata & 8'hcb) == ($past(bus_ctrl_lines) & 8'hcb))
        else $error("control lines wrong");
    chk_data_lines: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_data_lines
        |=> byte_port_rdata == $past(bus_data_lines))
        else $error("data lines wrong");
    chk_talk_shown: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_ctrl_lines
        && iface_state_in[gpib_status_pkg::state_talker_bit]
        |=> byte_port_rdata[5:4] == $past(bus_ctrl_lines[5:4]))
        else $error("handshake hidden while talker");
    chk_srq_shown: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_ctrl_lines
        && iface_state_in[gpib_status_pkg::ctl_active_bit]
        |=> byte_port_rdata[2] == $past(bus_ctrl_lines[2]))
        else $error("srq hidden while controller");
    chk_iface_word: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_iface_status
        |=> byte_port_rdata[7:1] == $past(iface_state_in[15:9]))
        else $error("interface status wrong");
    chk_lsb_in_word: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_iface_status
        |=> byte_port_rdata[0] == $past(last_addr_lsb))
        else $error("address lsb not shown");
    chk_ctrl_status: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_ctrl_status
        |=> byte_port_rdata == $past(iface_state_in[7:0]))
        else $error("controller status wrong");
    chk_irq_dma: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_irq_dma
        |=> byte_port_rdata == $past(irq_dma_bits))
        else $error("interrupt dma status wrong");
    chk_cmd_pass: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_cmd_pass
        |=> byte_port_rdata == $past(unknown_command))
        else $error("command pass-through wrong");
    chk_cause_hi_read: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_irq_status_hi
        |=> byte_port_rdata == $past(cause[15:8]))
        else $error("cause high read wrong");
    chk_cause_lo_read: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_irq_status_lo
        |=> byte_port_rdata == $past(cause[7:0]))
        else $error("cause low read wrong");
    chk_own_write: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_write && byte_port_addr == gpib_status_pkg::reg_own_address
        |=> own_address == $past(byte_port_wdata[4:0]))
        else $error("own address write lost");
    chk_clears_lo: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && clr_lo && cause_events[7:0] == 8'h00 |=> cause[7:0] == 8'h00)
        else $error("cause low not cleared by read");
    chk_data_ack: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_data_lines
        |=> data_read_ack)
        else $error("data read not acknowledged");
    chk_ack_pulse: assert property (@(posedge core_clk) disable iff (rst)
        !(byte_port_read && byte_port_addr == gpib_status_pkg::reg_data_lines)
        |=> !data_read_ack)
        else $error("data ack without data read");
    chk_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
        !byte_port_read |=> byte_port_rdata == 8'h00)
        else $error("read data without a read");
    chk_unmapped_zero: assert property (@(posedge core_clk) disable iff (rst)
        byte_port_read && !read_mapped(byte_port_addr) |=> byte_port_rdata == 8'h00)
        else $error("unmapped read not zero");
    // every cause bit is sticky until its own byte is read
    generate
        for (genvar g = 0; g < 16; g++)
        begin : cause_bits
            chk_cause_set: assert property (@(posedge core_clk) disable iff (rst)
                cause_events[g] |=> cause[g])
                else $error("cause bit lost");
            chk_cause_hold: assert property (@(posedge core_clk) disable iff (rst)
                cause[g] && !(byte_port_read && (g < 8 ? clr_lo : clr_hi)) |=> cause[g])
                else $error("cause bit dropped");
        end
    endgenerate
    cov_unmapped: cover property (@(posedge core_clk) disable iff (rst)
        byte_port_read && !read_mapped(byte_port_addr));
    cov_data_ack: cover property (@(posedge core_clk) disable iff (rst) data_read_ack);
    cov_irq: cover property (@(posedge core_clk) disable iff (rst) $rose(irq));
    cov_id_read: cover property (@(posedge core_clk) disable iff (rst)
        byte_port_read && byte_port_addr == gpib_status_pkg::reg_card_identity);
    cov_clear: cover property (@(posedge core_clk) disable iff (rst) byte_port_read && clr_lo);
endmodule
`default_nettype wire

// ---- gpib_bus_partner.sv ----
`default_nettype none
module gpib_bus_partner
(
    input wire logic core_clk,
    input wire logic shuffle,
    output logic [7:0] ctrl_lines,
    output logic [7:0] data_lines
);
    timeunit 1ns;
    timeprecision 1ps;
    integer seed = 32'h1f2e3d4c;
    logic [15:0] lines = 16'h0000;
    // lines move only on request, so a read sees a settled bus
    always @(posedge core_clk)
        if (shuffle)
            lines <= 16'($random(seed));
    assign {ctrl_lines, data_lines} = lines;
endmodule
`default_nettype wire

// ---- tb_gpib_status_interrupt_view.sv ----
`default_nettype none
module tb_gpib_status_interrupt_view;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] code = 7'h2a; // arbitrary value
    logic core_clk = 1'b0, rst = 1'b1, rd_s = 1'b0, wr_s = 1'b0, jmp = 1'b0, rec = 1'b0;
    logic shuffle = 1'b0, ack, irq, ack_seen;
    logic [4:0] addr = 5'h00, own;
    logic [7:0] wd = 8'h00, ra = 8'h00, unk = 8'h00, dma = 8'h00, rdata, rdata_b, fl_seen;
    logic [7:0] ctrl, data, d;
    logic [15:0] cause = 16'h0000, state = 16'h0000, en, cv;
    integer seed = 32'h6d1df18a, err_total = 0, num_checks = 0, cyc = 0;
    always #2 core_clk = ~core_clk;
    gpib_bus_partner gpib_bus_partner_inst (.core_clk(core_clk), .shuffle(shuffle),
        .ctrl_lines(ctrl), .data_lines(data));
    gpib_status_interrupt_view #(.card_code(code), .plug_in_card(1'b1))
        gpib_status_interrupt_view_inst (.core_clk(core_clk), .rst(rst), .byte_port_addr(addr),
        .byte_port_read(rd_s), .byte_port_write(wr_s), .byte_port_wdata(wd),
        .byte_port_rdata(rdata), .jumper_fitted(jmp), .cause_events(cause),
        .bus_ctrl_lines(ctrl), .bus_data_lines(data), .iface_state_in(state),
        .addr_recognised(rec), .recognised_address(ra), .unknown_command(unk),
        .irq_dma_bits(dma), .data_read_ack(ack), .own_address(own), .irq(irq));
    // built-in variant: identity byte floats
    gpib_status_interrupt_view #(.card_code(code), .plug_in_card(1'b0))
        builtin_inst (.core_clk(core_clk), .rst(rst), .byte_port_addr(addr),
        .byte_port_read(rd_s), .byte_port_write(wr_s), .byte_port_wdata(wd),
        .byte_port_rdata(rdata_b), .jumper_fitted(jmp), .cause_events(cause),
        .bus_ctrl_lines(ctrl), .bus_data_lines(data), .iface_state_in(state),
        .addr_recognised(rec), .recognised_address(ra), .unknown_command(unk),
        .irq_dma_bits(dma), .data_read_ack(), .own_address(), .irq());
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] snap_hi(input logic [7:0] c, input logic [15:0] s);
        snap_hi = c & {2'b11, s[9], s[9], 1'b1, s[6], 2'b11};
    endfunction
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        @(posedge core_clk) addr <= a;
        rd_s <= 1'b1;
        @(posedge core_clk) rd_s <= 1'b0;
        @(negedge core_clk) v = rdata;
        ack_seen = ack;
        fl_seen = rdata_b;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge core_clk) addr <= a;
        wr_s <= 1'b1;
        wd <= v;
        @(posedge core_clk) wr_s <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_total = err_total + 1;
            wrap_up();
        end
    end
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rd(gpib_status_pkg::reg_enable_lo, d);
        chk("enable_lo_reset", 8'h00, d);
        for (int j = 0; j < 2; j++)
        begin
            @(posedge core_clk) jmp <= j[0];
            rd(gpib_status_pkg::reg_card_identity, d);
            chk("identity", {j[0], code}, d);
            chk("identity_builtin", 8'hff, fl_seen);
        end
        for (int i = 0; i < 6; i++)
        begin
            en = (i == 0) ? 16'h0000 : 16'($random(seed));
            cv = (i == 0) ? 16'hffff : 16'($random(seed));
            wr(gpib_status_pkg::reg_enable_lo, en[7:0]);
            wr(gpib_status_pkg::reg_enable_hi, en[15:8]);
            rd(gpib_status_pkg::reg_enable_hi, d);
            chk("enable_hi", en[15:8], d);
            rd(gpib_status_pkg::reg_enable_lo, d);
            chk("enable_lo", en[7:0], d);
            @(posedge core_clk) cause <= cv;
            @(posedge core_clk) cause <= 16'h0000;
            @(negedge core_clk) chk("irq", {7'h00, |(cv & en)}, {7'h00, irq});
            rd(gpib_status_pkg::reg_irq_status_hi, d);
            chk("cause_hi", cv[15:8], d);
            rd(gpib_status_pkg::reg_irq_status_lo, d);
            chk("cause_lo", cv[7:0], d);
            rd(gpib_status_pkg::reg_irq_status_hi, d);
            chk("cause_hi_cleared", 8'h00, d);
            chk("irq_cleared", 8'h00, {7'h00, irq});
        end
        for (int i = 0; i < 8; i++)
        begin
            @(posedge core_clk) shuffle <= 1'b1;
            {state, ra, unk, dma} <= 40'({$random(seed), $random(seed)});
            rec <= 1'b1;
            @(posedge core_clk) shuffle <= 1'b0;
            rec <= 1'b0;
            rd(gpib_status_pkg::reg_ctrl_lines, d);
            chk("ctrl_lines", snap_hi(ctrl, state), d);
            chk("data_ack_idle", 8'h00, {7'h00, ack_seen});
            rd(gpib_status_pkg::reg_data_lines, d);
            chk("data_lines", data, d);
            chk("data_ack", 8'h01, {7'h00, ack_seen});
            rd(gpib_status_pkg::reg_iface_status, d);
            chk("iface_hi", {state[15:9], ra[0]}, d);
            rd(gpib_status_pkg::reg_ctrl_status, d);
            chk("ctrl_status", state[7:0], d);
            rd(gpib_status_pkg::reg_irq_dma, d);
            chk("irq_dma", dma, d);
            rd(gpib_status_pkg::reg_cmd_pass, d);
            chk("cmd_pass", unk, d);
            rd(5'h07, d);
            chk("unmapped", 8'h00, d);
            wr(gpib_status_pkg::reg_own_address, ra);
            @(negedge core_clk) chk("own_address", {3'h0, ra[4:0]}, {3'h0, own});
        end
        wrap_up();
    end
endmodule
`default_nettype wire
